// ---- core/tcp_pkg.sv ----
// Constants, field layouts and carrier types for the 8-bit timer/counter with its shared prescaler.
// Assumes a 100 MHz oscillator clock from which four internal phases make one instruction cycle.
package tcp_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam logic [7:0] TCP_IDX_COUNT   = 8'h01;
  localparam logic [7:0] TCP_IDX_INTCTL  = 8'h0b;
  localparam logic [7:0] TCP_IDX_OPTION  = 8'h81;
  localparam int         TCP_ADDR_W      = 10;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int         TCP_INT_OVF_EN  = 5;
  localparam int         TCP_INT_EXT_EN  = 4;
  localparam int         TCP_INT_OVF_FLG = 2;
  localparam int         TCP_INT_EXT_FLG = 1;
  localparam logic [7:0] TCP_RST_COUNT   = 8'h00;
  localparam logic [7:0] TCP_RST_INTCTL  = 8'h00;
  localparam logic [7:0] TCP_RST_OPTION  = 8'hff;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int         TCP_CLK_PERIOD_NS = 10;
  localparam int         TCP_PHASES        = 4;
  localparam logic [1:0] TCP_PH_Q2         = 2'h1;
  localparam logic [1:0] TCP_PH_Q4         = 2'h3;
  localparam logic [1:0] TCP_WR_INHIBIT_IC = 2'h2;
  localparam int         TCP_EXT_MIN_NS    = 2 * TCP_CLK_PERIOD_NS;
  localparam int         TCP_EXT_MIN_CYC   = (TCP_EXT_MIN_NS + TCP_CLK_PERIOD_NS - 1) / TCP_CLK_PERIOD_NS;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic       pullup_global_disable;
    logic       ext_irq_edge;
    logic       count_source_sel;
    logic       count_edge_sel;
    logic       prescaler_assign;
    logic [2:0] prescale_rate;
  } tcp_option_s;

  // Mask of low prescaler bits that must be all ones for one divided tick.
  function automatic logic [7:0] tcp_rate_mask(input logic [2:0] rate, input logic to_watchdog);
    logic [3:0] sh;
    logic [8:0] m;
    sh = to_watchdog ? {1'b0, rate} : ({1'b0, rate} + 4'h1);
    m  = (9'h001 << sh) - 9'h001;
    return m[7:0];
  endfunction : tcp_rate_mask

  function automatic logic [TCP_ADDR_W-1:0] tcp_addr_of(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction : tcp_addr_of

endpackage : tcp_pkg

// ---- core/tcp_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for a pin input.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ps
module tcp_pin_sync
  import tcp_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // The first stage is seen only by the second; the level moves once stages two and three agree.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign level_o = level_r;

endmodule : tcp_pin_sync

// ---- core/tcp_timer.sv ----
// Timer/counter with shared prescaler, reached over an Avalon-MM slave with waitrequest.
// Assumes the processor core supplies sleep and watchdog-clear strobes and the watchdog core its raw tick.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module tcp_timer
  import tcp_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [TCP_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic                  ext_count_input_i,
  input  wire logic                  sleep_i,
  input  wire logic                  watchdog_clear_instr_i,
  input  wire logic                  wdt_tick_i,
  input  wire logic [5:0]            pullup_pin_en_i,
  output logic [5:0]                 pullup_en_o,
  output logic                       timer_irq_o,
  output logic                       ext_irq_event_o,
  output logic                       wdt_post_tick_o,
  output logic                       wdt_clear_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [7:0]  count_r;
  logic [7:0]  count_nxt;
  logic [7:0]  intctl_r;
  logic [7:0]  intctl_nxt;
  tcp_option_s opt_r;
  tcp_option_s opt_nxt;
  logic [7:0]  psc_r;
  logic [7:0]  psc_nxt;
  logic [1:0]  phase_r;
  logic [1:0]  inhibit_r;
  logic [1:0]  inhibit_nxt;
  logic        pending_r;
  logic        pending_nxt;
  logic        pin_prev_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [5:0]  pullup_r;
  logic        ext_evt_r;
  logic        post_tick_r;
  logic        wdt_clr_r;

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  logic pin_level;

  tcp_pin_sync u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (ext_count_input_i),
    .level_o   (pin_level)
  );

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  wire       bus_req    = avs_read_i | avs_write_i;
  wire       bus_fire   = bus_req & ack_r;
  wire       lane0      = avs_byteenable_i[0];
  wire       hit_count  = (avs_address_i == tcp_addr_of(TCP_IDX_COUNT));
  wire       hit_intctl = (avs_address_i == tcp_addr_of(TCP_IDX_INTCTL));
  wire       hit_option = (avs_address_i == tcp_addr_of(TCP_IDX_OPTION));
  wire       wr_fire    = bus_fire & avs_write_i & lane0;
  wire       wr_count   = wr_fire & hit_count;
  wire       wr_intctl  = wr_fire & hit_intctl;
  wire       wr_option  = wr_fire & hit_option;
  wire [7:0] wbyte      = avs_writedata_i[7:0];
  wire [7:0] rd_sel;

  assign rd_sel = hit_count  ? count_r :
                  hit_intctl ? intctl_r :
                  hit_option ? opt_r :
                  8'h00;

  // One wait cycle per access; unmapped addresses read zero and ignore writes.
  assign avs_waitrequest_o = bus_req & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  // ==========================================================================
  // Phase clocks and count sources
  // ==========================================================================
  wire       icyc_tick   = (phase_r == TCP_PH_Q4);
  wire       sample_ph   = (phase_r == TCP_PH_Q2) | (phase_r == TCP_PH_Q4);
  wire       pin_rise    = pin_level & ~pin_prev_r;
  wire       pin_fall    = ~pin_level & pin_prev_r;
  wire       ext_edge    = opt_r.count_edge_sel ? pin_fall : pin_rise;
  wire       src_evt     = opt_r.count_source_sel ? ext_edge : icyc_tick;
  wire       to_wdt      = opt_r.prescaler_assign;
  wire [7:0] rate_mask   = tcp_rate_mask(opt_r.prescale_rate, to_wdt);
  wire       psc_full    = ((psc_r & rate_mask) == rate_mask);
  wire       timer_run   = ~sleep_i;
  wire       psc_in_evt  = to_wdt ? wdt_tick_i : (src_evt & timer_run);
  wire       timer_evt   = to_wdt ? (src_evt & timer_run) :
                                    (psc_in_evt & psc_full);
  wire       do_inc      = pending_r & sample_ph & timer_run & (inhibit_r == 2'h0);
  wire       wrap        = do_inc & (count_r == 8'hff);
  wire       int_rise    = pin_rise & opt_r.ext_irq_edge;
  wire       int_fall    = pin_fall & ~opt_r.ext_irq_edge;
  wire       ext_int_evt = int_rise | int_fall;
  wire       psc_clear   = (wr_count & ~to_wdt) |
                           (watchdog_clear_instr_i & to_wdt);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = wbyte;
    end else if (do_inc) begin
      count_nxt = count_r + 8'h01;
    end
  end

  // Hardware sets win over a software write in the same cycle; the flag is never cleared by hardware.
  always_comb begin
    intctl_nxt = wr_intctl ? wbyte : intctl_r;
    if (wrap) begin
      intctl_nxt[TCP_INT_OVF_FLG] = 1'b1;
    end
    if (ext_int_evt) begin
      intctl_nxt[TCP_INT_EXT_FLG] = 1'b1;
    end
  end

  assign opt_nxt = wr_option ? tcp_option_s'(wbyte) : opt_r;

  // The divider cannot be read or loaded; it only counts and clears.
  always_comb begin
    psc_nxt = psc_r;
    if (psc_clear) begin
      psc_nxt = 8'h00;
    end else if (psc_in_evt) begin
      psc_nxt = psc_r + 8'h01;
    end
  end

  // Inhibit counts down on instruction-cycle boundaries after a count write.
  always_comb begin
    inhibit_nxt = inhibit_r;
    if (wr_count) begin
      inhibit_nxt = TCP_WR_INHIBIT_IC;
    end else if (icyc_tick && inhibit_r != 2'h0) begin
      inhibit_nxt = inhibit_r - 2'h1;
    end
  end

  // An event waits for the next phase-two or phase-four sample; a count write discards it.
  always_comb begin
    pending_nxt = pending_r;
    if (wr_count) begin
      pending_nxt = 1'b0;
    end else if (timer_evt) begin
      pending_nxt = 1'b1;
    end else if (sample_ph) begin
      pending_nxt = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r    <= TCP_RST_COUNT;
      intctl_r   <= TCP_RST_INTCTL;
      opt_r      <= tcp_option_s'(TCP_RST_OPTION);
      psc_r      <= 8'h00;
      inhibit_r  <= 2'h0;
      pending_r  <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      intctl_r   <= intctl_nxt;
      opt_r      <= opt_nxt;
      psc_r      <= psc_nxt;
      inhibit_r  <= inhibit_nxt;
      pending_r  <= pending_nxt;
    end
  end

  // Phase counter stops in sleep; a phase held at phase four keeps the instruction-cycle tick high, so timer_run gates the count sources.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r    <= 2'h0;
      pin_prev_r <= 1'b0;
    end else begin
      phase_r    <= timer_run ? (phase_r + 2'h1) : phase_r;
      pin_prev_r <= pin_level;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= bus_req & ~ack_r;
      rdata_r <= (bus_req & ~ack_r) ? {24'h00_0000, rd_sel} : rdata_r;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pullup_r    <= 6'h00;
      ext_evt_r   <= 1'b0;
      post_tick_r <= 1'b0;
      wdt_clr_r   <= 1'b0;
    end else begin
      pullup_r    <= opt_r.pullup_global_disable ? 6'h00 : pullup_pin_en_i;
      ext_evt_r   <= ext_int_evt;
      post_tick_r <= to_wdt & wdt_tick_i & psc_full;
      wdt_clr_r   <= watchdog_clear_instr_i;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign timer_irq_o     = intctl_r[TCP_INT_OVF_FLG] & intctl_r[TCP_INT_OVF_EN];
  assign pullup_en_o     = pullup_r;
  assign ext_irq_event_o = ext_evt_r;
  assign wdt_post_tick_o = post_tick_r;
  assign wdt_clear_o     = wdt_clr_r;

endmodule : tcp_timer

// ---- verif/tcp_timer_monitor.sv ----
// Checker for the timer/counter block, watching only its top-level ports.
// Assumes a master that holds each request until it samples waitrequest low.
`timescale 1ns/1ps
module tcp_timer_monitor
  import tcp_pkg::*;
(
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  input wire logic [TCP_ADDR_W-1:0] avs_address_i,
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire logic [31:0]           avs_writedata_i,
  input wire logic [3:0]            avs_byteenable_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  input wire logic                  ext_count_input_i,
  input wire logic                  sleep_i,
  input wire logic                  watchdog_clear_instr_i,
  input wire logic                  wdt_tick_i,
  input wire logic [5:0]            pullup_pin_en_i,
  input wire logic [5:0]            pullup_en_o,
  input wire logic                  timer_irq_o,
  input wire logic                  ext_irq_event_o,
  input wire logic                  wdt_post_tick_o,
  input wire logic                  wdt_clear_o
);
  // ==========
  // Decode helpers
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic [9:0] a_cnt   = {TCP_IDX_COUNT, 2'h0};
  wire logic [9:0] a_int   = {TCP_IDX_INTCTL, 2'h0};
  wire logic [9:0] a_opt   = {TCP_IDX_OPTION, 2'h0};
  wire logic       done_wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  wire logic       mapped  = (avs_address_i == a_cnt) | (avs_address_i == a_int) | (avs_address_i == a_opt);
  sequence s_opt_wr;
    done_wr && avs_address_i == a_opt;
  endsequence
  sequence s_asleep;
    (sleep_i && !avs_write_i) [*3];
  endsequence
  // ==========
  // Assertions
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held longer than one cycle");
  a_rd_unmapped: assert property (avs_read_i && !avs_waitrequest_o && !mapped |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (done_wr && avs_address_i == a_int && !avs_writedata_i[5] |=> !timer_irq_o)
    else $error("timer interrupt not masked");
  a_pullup_off: assert property (s_opt_wr ##0 avs_writedata_i[7] |-> ##2 pullup_en_o == 6'h00)
    else $error("pull-ups not disabled");
  a_pullup_follow: assert property (s_opt_wr ##0 !avs_writedata_i[7] |-> ##2 pullup_en_o == $past(pullup_pin_en_i))
    else $error("pull-ups not following pins");
  a_clear_pulse: assert property (watchdog_clear_instr_i |=> wdt_clear_o)
    else $error("watchdog clear not passed on");
  a_post_cause: assert property (wdt_post_tick_o |-> $past(wdt_tick_i))
    else $error("postscaler tick without raw tick");
  a_sleep_frozen: assert property (s_asleep |=> !$rose(timer_irq_o))
    else $error("timer interrupt raised in sleep");
endmodule : tcp_timer_monitor

bind tcp_timer tcp_timer_monitor i_tcp_timer_monitor (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .ext_count_input_i,
  .sleep_i, .watchdog_clear_instr_i, .wdt_tick_i, .pullup_pin_en_i, .pullup_en_o, .timer_irq_o,
  .ext_irq_event_o, .wdt_post_tick_o, .wdt_clear_o);

// ---- verif/tcp_ext_src.sv ----
// External clock source model for the count pin.
// Assumes callers enter its task just after a rising edge of sys_clk_i.
`timescale 1ns/1ps
module tcp_ext_src (
  input  wire logic sys_clk_i,
  output logic      pin_o
);
  initial pin_o = 1'h0;
  // ==========
  // Pin toggling
  // Widths below two clocks are raised to two, since the pin sampler would miss them.
  task automatic toggle(input int k, input int w);
    for (int i = 0; i < k; i++) begin
      pin_o <= ~pin_o;
      repeat ((w < 2) ? 2 : w) @(posedge sys_clk_i);
    end
  endtask : toggle
endmodule : tcp_ext_src

// ---- verif/tb_top.sv ----
// Self-checking bench for the timer/counter with shared prescaler.
// Assumes the checker binds itself to the design and the pin model shares the clock.
`timescale 1ns/1ps
module tb_top
  import tcp_pkg::*;
;
  localparam logic [9:0] A_CNT = {TCP_IDX_COUNT, 2'h0};
  localparam logic [9:0] A_INT = {TCP_IDX_INTCTL, 2'h0};
  localparam logic [9:0] A_OPT = {TCP_IDX_OPTION, 2'h0};
  logic                  sys_clk_i = 1'h0;
  logic                  rst_i = 1'h1;
  logic [TCP_ADDR_W-1:0] avs_address_i = 10'h000;
  logic                  avs_read_i = 1'h0;
  logic                  avs_write_i = 1'h0;
  logic [31:0]           avs_writedata_i = 32'h0;
  logic [3:0]            avs_byteenable_i = 4'h1;
  logic                  sleep_i = 1'h0;
  logic                  watchdog_clear_instr_i = 1'h0;
  logic                  wdt_tick_i = 1'h0;
  logic [5:0]            pullup_pin_en_i = 6'h00;
  logic [31:0]           avs_readdata_o;
  logic [5:0]            pullup_en_o;
  logic                  avs_waitrequest_o, ext_count_input_i, timer_irq_o;
  logic                  ext_irq_event_o, wdt_post_tick_o, wdt_clear_o;
  int                    mismatches = 0, comparisons = 0, cycles = 0, n_evt = 0, n_post = 0;
  int                    regm[int];

  tcp_timer i_tcp_timer (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .ext_count_input_i, .sleep_i, .watchdog_clear_instr_i,
    .wdt_tick_i, .pullup_pin_en_i, .pullup_en_o, .timer_irq_o, .ext_irq_event_o, .wdt_post_tick_o, .wdt_clear_o);
  tcp_ext_src i_tcp_ext_src (.sys_clk_i, .pin_o(ext_count_input_i));

  always #(TCP_CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    n_evt += int'(ext_irq_event_o === 1'h1);
    n_post += int'(wdt_post_tick_o === 1'h1);
    if (cycles == 40000) begin
      mismatches++;
      summarize();
    end
  end
  // ==========
  // Shared tasks
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  function automatic int mdl(input int a);
    return regm.exists(a) ? regm[a] : 0;
  endfunction : mdl
  task automatic wdt_clr();
    watchdog_clear_instr_i <= 1'h1;
    @(posedge sys_clk_i);
    watchdog_clear_instr_i <= 1'h0;
  endtask : wdt_clr
  task automatic chk(input string nm, input int e, input logic [31:0] g, input int t);
    comparisons++;
    if (g !== 32'(e) && ($isunknown(g) || g > 32'(e + t) || g + 32'(t) < 32'(e))) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk
  // Waitrequest and read data are read right after the rising edge, so they show what the design sampled there.
  // Only the cycle ceiling ends a wait that never completes.
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] b,
                      output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= b;
    avs_read_i <= ~w;
    avs_write_i <= w;
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_o !== 1'h0);
    q = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
    if (w && b[0]) begin
      regm[a] = d;
    end
  endtask : xfer
  // ==========
  // Scenarios
  initial begin
    logic [31:0] q;
    int          k;
    int          ad[5];
    void'($urandom(32'h6477e9fa));
    regm[A_CNT] = 0;
    regm[A_INT] = 0;
    regm[A_OPT] = 255;
    ad = '{A_CNT, A_INT, A_OPT, 10'h3f0, 10'h005};
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    foreach (ad[i]) begin
      xfer(1'h0, 10'(ad[i]), 8'h00, 4'h1, q);
      chk("reset read", mdl(ad[i]), q, 0);
    end
    for (int i = 0; i < 2; i++) begin
      pullup_pin_en_i <= 6'($urandom);
      xfer(1'h1, A_OPT, i ? 8'h88 : 8'h08, 4'h1, q);
      repeat (3) @(posedge sys_clk_i);
      chk("pull-ups", i ? 0 : int'(pullup_pin_en_i), pullup_en_o, 0);
    end
    for (int r = -1; r < 8; r++) begin
      k = (r < 0) ? 1 : 2 << r;
      if (r == 0) begin
        wdt_clr();
      end
      xfer(1'h1, A_OPT, (r < 0) ? 8'h08 : 8'(r), 4'h1, q);
      xfer(1'h1, A_CNT, 8'h00, 4'h1, q);
      repeat (32 * k) @(posedge sys_clk_i);
      xfer(1'h0, A_CNT, 8'h00, 4'h1, q);
      chk("timer count", (32 * k - 6) / (4 * k), q, 1);
    end
    wdt_clr();
    xfer(1'h1, A_CNT, 8'h00, 4'h1, q);
    xfer(1'h1, A_OPT, 8'h2f, 4'h1, q);
    wdt_clr();
    xfer(1'h1, A_OPT, 8'h08, 4'h1, q);
    xfer(1'h1, A_INT, 8'h20, 4'h1, q);
    xfer(1'h1, A_CNT, 8'hfc, 4'h1, q);
    xfer(1'h0, A_CNT, 8'h00, 4'h1, q);
    chk("held count", 8'hfc, q, 0);
    for (k = 0; k < 60 && timer_irq_o !== 1'h1; k++) begin
      @(posedge sys_clk_i);
    end
    chk("cycles to overflow", 21, k, 4);
    regm[A_INT] = 8'h24;
    xfer(1'h0, A_INT, 8'h00, 4'h1, q);
    chk("flag set", mdl(A_INT), q, 0);
    xfer(1'h1, A_INT, 8'h04, 4'h1, q);
    repeat (2) @(posedge sys_clk_i);
    chk("masked irq", 0, timer_irq_o, 0);
    xfer(1'h0, A_INT, 8'h00, 4'h1, q);
    chk("flag kept", mdl(A_INT), q, 0);
    sleep_i <= 1'h1;
    xfer(1'h1, A_CNT, 8'hfc, 4'h1, q);
    xfer(1'h1, A_CNT, 8'h11, 4'h0, q);
    repeat (100) @(posedge sys_clk_i);
    xfer(1'h0, A_CNT, 8'h00, 4'h1, q);
    chk("asleep count", mdl(A_CNT), q, 0);
    sleep_i <= 1'h0;
    for (int r = 0; r < 8; r++) begin
      xfer(1'h1, A_OPT, 8'h08 | 8'(r), 4'h1, q);
      wdt_clr();
      n_post = 0;
      repeat ((2 << r) + 1) begin
        @(posedge sys_clk_i);
        wdt_tick_i <= 1'h1;
        @(posedge sys_clk_i);
        wdt_tick_i <= 1'h0;
      end
      repeat (3) @(posedge sys_clk_i);
      chk("postscaler ticks", ((2 << r) + 1) >> r, n_post, 0);
    end
    for (int s = 0; s < 2; s++) begin
      k = 2 + $urandom % 4;
      xfer(1'h1, A_OPT, s ? 8'h38 : 8'h68, 4'h1, q);
      xfer(1'h1, A_CNT, 8'h00, 4'h1, q);
      repeat (12) @(posedge sys_clk_i);
      n_evt = 0;
      i_tcp_ext_src.toggle(2 * k + 1, 2 + $urandom % 3);
      repeat (12) @(posedge sys_clk_i);
      xfer(1'h0, A_CNT, 8'h00, 4'h1, q);
      chk("pin count", k + 1 - s, q, 0);
      chk("pin events", k + 1 - s, n_evt, 0);
      i_tcp_ext_src.toggle(1, 2);
    end
    summarize();
  end
endmodule : tb_top
